// ---- src/cag_regs.svh ----
// Purpose: constants for the address generation block
// Assumes: 16-bit unified memory space
// Notes: definitions only
`ifndef CAG_REGS_SVH
`define CAG_REGS_SVH
`define CAG_RESET_VEC_LO 16'h0000
`define CAG_RESET_VEC_HI 16'h0001
`define CAG_TABLE_BASE 16'h0040
`define CAG_SHORT_HI 7'h7f
`define CAG_SHORT_SPLIT 8'h20
`define CAG_SFR_HI 8'hff
`define CAG_RAM_LO 16'hfd00
`define CAG_RAM_HI 16'hfeff
`define CAG_ONE 16'h0001
`define CAG_MINUS_ONE 16'hffff
`define CAG_CLEAR16 16'h0000
`define CAG_SHORT_FIRST 16'hfe20
`define CAG_SHORT_LAST 16'hff1f
`endif

// ---- src/cag_pkg.sv ----
// Purpose: types for the address generation block
// Assumes: nothing
// Notes: operation codes from the decoder
`default_nettype none
package cag_pkg;
  typedef enum logic [3:0] {
    CAG_OP_NONE = 4'h0,
    CAG_OP_SEQ = 4'h1,
    CAG_OP_REL = 4'h2,
    CAG_OP_IMM = 4'h3,
    CAG_OP_TBL = 4'h4,
    CAG_OP_REG = 4'h5,
    CAG_OP_DIR = 4'h6,
    CAG_OP_SHORT = 4'h7,
    CAG_OP_SFR = 4'h8,
    CAG_OP_IND = 4'h9,
    CAG_OP_BASED = 4'ha,
    CAG_OP_PUSH = 4'hb,
    CAG_OP_POP = 4'hc,
    CAG_OP_GPR = 4'hd
  } cag_op_t;
  typedef enum logic [1:0] {
    CAG_ST_IDLE = 2'b00,
    CAG_ST_LO = 2'b01,
    CAG_ST_HI = 2'b11
  } cag_state_t;
endpackage
`default_nettype wire

// ---- src/cag_core.sv ----
// Purpose: branch target and operand address generation
// Assumes: decoder holds op_i valid one cycle with strobe start_i
// Notes: vector fetches read bytes over mem_rd_o / mem_data_i
//
// Overview of operation
// - fetch pointer steps one per fetched byte
// - relative target adds sign-extended offset
// - relative form serves short and conditional jumps
// - absolute jump loads sixteen-bit immediate
// - table call reads entry at 40H plus twice the index
// - register jump loads accum_pair
// - direct address is immediate unchanged
// - short direct window FE20H to FF1FH
// - bit 8 set for field below 20H
// - sixteen-bit short direct takes even addresses
// - special register address is FF plus field
// - three-bit register code or pair select
// - indirect uses second_pair or base_pair
// - based adds zero-extended offset to base_pair
// - stack ops address through stack_top
// - stack only legal in high-speed RAM
// - predecrement on write, postincrement on read
// - vector low byte even, high byte odd
// - reset loads fetch pointer from vector
`include "cag_regs.svh"
`default_nettype none
module cag_core
  import cag_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // decoder request
  input wire logic start_i,
  input wire cag_op_t op_i,
  input wire logic [15:0] imm16_i,
  input wire logic [7:0] imm8_i,
  input wire logic [4:0] tbl_idx_i,
  input wire logic [2:0] reg_code_i,
  input wire logic pair_sel_i,
  input wire logic wide_i,
  input wire logic [15:0] accum_pair_i,
  input wire logic [15:0] second_pair_i,
  input wire logic [15:0] base_pair_i,
  // stack pointer load
  input wire logic sp_load_i,
  input wire logic [15:0] sp_value_i,
  // memory read port for vectors
  input wire logic [7:0] mem_data_i,
  output logic mem_rd_o,
  output logic [15:0] mem_addr_o,
  // results
  output logic [15:0] fetch_pointer_o,
  output logic [15:0] stack_top_o,
  output logic [15:0] eff_addr_o,
  output logic eff_valid_o,
  output logic [2:0] reg_sel_o,
  output logic reg_wide_o,
  output logic addr_err_o,
  output logic busy_o
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [15:0] add16(input logic [15:0] a,
                                        input logic [15:0] b);
    logic [16:0] s;
    s = {1'b0, a} + {1'b0, b};
    add16 = s[15:0]; // carry dropped
  endfunction

  function automatic logic in_ram(input logic [15:0] a);
    in_ram = (a >= `CAG_RAM_LO) && (a <= `CAG_RAM_HI);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state

  cag_state_t state;
  logic [15:0] fetch_pointer;
  logic [15:0] stack_top;
  logic [7:0] vec_lo;
  logic boot;
  logic [15:0] vec_addr;
  logic [15:0] next_sp;
  logic [15:0] tbl_addr;

  assign fetch_pointer_o = fetch_pointer;
  assign stack_top_o = stack_top;

  // table entry address, two bytes per entry
  assign tbl_addr = add16(`CAG_TABLE_BASE,
                          {10'h000, tbl_idx_i, 1'b0});

  // push predecrements, pop uses current value
  always_comb begin
    next_sp = stack_top;
    if (start_i && op_i == CAG_OP_PUSH) begin
      next_sp = add16(stack_top, `CAG_MINUS_ONE);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // vector fetch sequencer

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= CAG_ST_IDLE;
      boot <= 1'b1;
      busy_o <= 1'b1;
      vec_addr <= `CAG_CLEAR16;
      vec_lo <= 8'h00;
      mem_rd_o <= 1'b0;
      mem_addr_o <= `CAG_CLEAR16;
    end else begin
      // busy follows the next state, so it leaves a flop
      unique case (state)
        CAG_ST_IDLE: begin
          if (boot) begin
            vec_addr <= `CAG_RESET_VEC_LO;
            mem_addr_o <= `CAG_RESET_VEC_LO;
            mem_rd_o <= 1'b1;
            boot <= 1'b0;
            state <= CAG_ST_LO;
          end else if (start_i && op_i == CAG_OP_TBL) begin
            vec_addr <= tbl_addr;
            mem_addr_o <= tbl_addr;
            mem_rd_o <= 1'b1;
            busy_o <= 1'b1;
            state <= CAG_ST_LO;
          end else begin
            mem_rd_o <= 1'b0;
            busy_o <= 1'b0;
          end
        end
        CAG_ST_LO: begin
          vec_lo <= mem_data_i; // low byte at even address
          mem_addr_o <= add16(vec_addr, `CAG_ONE);
          state <= CAG_ST_HI;
        end
        CAG_ST_HI: begin
          mem_rd_o <= 1'b0;
          busy_o <= 1'b0;
          state <= CAG_ST_IDLE;
        end
        default: begin
          state <= CAG_ST_IDLE;
          busy_o <= boot;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // fetch pointer

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      fetch_pointer <= `CAG_CLEAR16;
    end else if (state == CAG_ST_HI) begin
      fetch_pointer <= {mem_data_i, vec_lo};
    end else if (start_i && state == CAG_ST_IDLE && !boot) begin
      unique case (op_i)
        CAG_OP_SEQ: fetch_pointer <= add16(fetch_pointer, `CAG_ONE);
        // fetch_pointer already past the jump
        CAG_OP_REL: fetch_pointer <= add16(fetch_pointer,
                                           {{8{imm8_i[7]}}, imm8_i});
        CAG_OP_IMM: fetch_pointer <= imm16_i;
        CAG_OP_REG: fetch_pointer <= accum_pair_i;
        default: fetch_pointer <= fetch_pointer;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // stack pointer

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      stack_top <= `CAG_CLEAR16;
    end else if (sp_load_i) begin
      stack_top <= sp_value_i;
    end else if (start_i && op_i == CAG_OP_PUSH) begin
      stack_top <= next_sp;
    end else if (start_i && op_i == CAG_OP_POP) begin
      stack_top <= add16(stack_top, `CAG_ONE);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // operand address

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      eff_addr_o <= `CAG_CLEAR16;
      eff_valid_o <= 1'b0;
      reg_sel_o <= 3'h0;
      reg_wide_o <= 1'b0;
      addr_err_o <= 1'b0;
    end else begin
      eff_valid_o <= 1'b0;
      addr_err_o <= 1'b0;
      if (start_i) begin
        unique case (op_i)
          CAG_OP_DIR: begin
            eff_addr_o <= imm16_i;
            eff_valid_o <= 1'b1;
          end
          CAG_OP_SHORT: begin
            eff_addr_o <= {`CAG_SHORT_HI, (imm8_i < `CAG_SHORT_SPLIT),
                           imm8_i};
            eff_valid_o <= !(wide_i && imm8_i[0]);
            addr_err_o <= wide_i && imm8_i[0]; // odd word refused
          end
          CAG_OP_SFR: begin
            eff_addr_o <= {`CAG_SFR_HI, imm8_i};
            eff_valid_o <= 1'b1;
          end
          CAG_OP_IND: begin
            eff_addr_o <= pair_sel_i ? base_pair_i : second_pair_i;
            eff_valid_o <= 1'b1;
          end
          CAG_OP_BASED: begin
            eff_addr_o <= add16(base_pair_i, {8'h00, imm8_i});
            eff_valid_o <= 1'b1;
          end
          CAG_OP_PUSH, CAG_OP_POP: begin
            eff_addr_o <= next_sp;
            eff_valid_o <= in_ram(next_sp);
            addr_err_o <= !in_ram(next_sp);
          end
          CAG_OP_GPR: begin
            // pair code in bits 2:1 when wide
            reg_sel_o <= wide_i ? {reg_code_i[2:1], 1'b0} : reg_code_i;
            reg_wide_o <= wide_i;
          end
          default: begin
            eff_valid_o <= 1'b0;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  a_seq_step: assert property (@(posedge clk_i) disable iff (rst_i)
    start_i && op_i == CAG_OP_SEQ && state == CAG_ST_IDLE && !boot
    |=> fetch_pointer == $past(fetch_pointer) + `CAG_ONE)
    else $error("fetch pointer did not step");

  a_rel_target: assert property (@(posedge clk_i) disable iff (rst_i)
    start_i && op_i == CAG_OP_REL && state == CAG_ST_IDLE && !boot
    |=> fetch_pointer == $past(fetch_pointer)
        + {{8{$past(imm8_i[7])}}, $past(imm8_i)})
    else $error("relative target wrong");

  a_imm_jump: assert property (@(posedge clk_i) disable iff (rst_i)
    start_i && op_i == CAG_OP_IMM && state == CAG_ST_IDLE && !boot
    |=> fetch_pointer == $past(imm16_i))
    else $error("absolute jump wrong");

  a_reg_jump: assert property (@(posedge clk_i) disable iff (rst_i)
    start_i && op_i == CAG_OP_REG && state == CAG_ST_IDLE && !boot
    |=> fetch_pointer == $past(accum_pair_i))
    else $error("register jump wrong");

  // table call request taken while idle
  sequence s_tbl_req;
    start_i && op_i == CAG_OP_TBL && state == CAG_ST_IDLE && !boot;
  endsequence

  sequence s_vec_read;
    state == CAG_ST_LO ##1 state == CAG_ST_HI;
  endsequence

  a_tbl_addr: assert property (@(posedge clk_i) disable iff (rst_i)
    s_tbl_req |=> mem_rd_o
    && mem_addr_o == `CAG_TABLE_BASE + {10'h000, $past(tbl_idx_i), 1'b0})
    else $error("table entry address wrong");

  a_tbl_seq: assert property (@(posedge clk_i) disable iff (rst_i)
    s_tbl_req |=> s_vec_read)
    else $error("table entry not read in two steps");

  a_vec_pair: assert property (@(posedge clk_i) disable iff (rst_i)
    s_vec_read |=> fetch_pointer == {$past(mem_data_i), vec_lo})
    else $error("vector byte order wrong");

  a_dir_pass: assert property (@(posedge clk_i) disable iff (rst_i)
    start_i && op_i == CAG_OP_DIR
    |=> eff_valid_o && eff_addr_o == $past(imm16_i))
    else $error("direct address altered");

  a_short_win: assert property (@(posedge clk_i) disable iff (rst_i)
    start_i && op_i == CAG_OP_SHORT |=>
    eff_addr_o >= `CAG_SHORT_FIRST && eff_addr_o <= `CAG_SHORT_LAST)
    else $error("short direct outside window");

  a_short_bit8: assert property (@(posedge clk_i) disable iff (rst_i)
    start_i && op_i == CAG_OP_SHORT
    |=> eff_addr_o == {`CAG_SHORT_HI, ($past(imm8_i) < `CAG_SHORT_SPLIT),
                       $past(imm8_i)})
    else $error("short direct expansion wrong");

  a_short_even: assert property (@(posedge clk_i) disable iff (rst_i)
    start_i && op_i == CAG_OP_SHORT && wide_i && imm8_i[0]
    |=> addr_err_o && !eff_valid_o)
    else $error("odd word short direct accepted");

  a_sfr_page: assert property (@(posedge clk_i) disable iff (rst_i)
    start_i && op_i == CAG_OP_SFR |=> eff_addr_o[15:8] == `CAG_SFR_HI)
    else $error("sfr address outside page");

  a_gpr_pair: assert property (@(posedge clk_i) disable iff (rst_i)
    start_i && op_i == CAG_OP_GPR && wide_i
    |=> reg_wide_o && reg_sel_o == {$past(reg_code_i[2:1]), 1'b0})
    else $error("register pair select wrong");

  a_ind_pair: assert property (@(posedge clk_i) disable iff (rst_i)
    start_i && op_i == CAG_OP_IND
    |=> eff_valid_o
        && eff_addr_o == ($past(pair_sel_i) ? $past(base_pair_i)
                                            : $past(second_pair_i)))
    else $error("indirect pair wrong");

  a_based_sum: assert property (@(posedge clk_i) disable iff (rst_i)
    start_i && op_i == CAG_OP_BASED
    |=> eff_addr_o == $past(base_pair_i) + {8'h00, $past(imm8_i)})
    else $error("based address wrong");

  a_stack_ram: assert property (@(posedge clk_i) disable iff (rst_i)
    eff_valid_o && $past(op_i == CAG_OP_PUSH || op_i == CAG_OP_POP)
    |-> eff_addr_o >= `CAG_RAM_LO && eff_addr_o <= `CAG_RAM_HI)
    else $error("stack address outside ram");

  a_stack_err: assert property (@(posedge clk_i) disable iff (rst_i)
    start_i && (op_i == CAG_OP_PUSH || op_i == CAG_OP_POP)
    && !in_ram(next_sp) |=> addr_err_o && !eff_valid_o)
    else $error("stack outside ram not refused");

  a_push_dec: assert property (@(posedge clk_i) disable iff (rst_i)
    start_i && op_i == CAG_OP_PUSH && !sp_load_i
    |=> stack_top == $past(stack_top) - `CAG_ONE)
    else $error("push did not predecrement");

  a_pop_inc: assert property (@(posedge clk_i) disable iff (rst_i)
    start_i && op_i == CAG_OP_POP && !sp_load_i
    |=> stack_top == $past(stack_top) + `CAG_ONE)
    else $error("pop did not postincrement");

  a_boot_vec: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(boot) |-> mem_addr_o == `CAG_RESET_VEC_LO && mem_rd_o)
    else $error("reset vector not read");

endmodule
`default_nettype wire

// ---- tb/cag_mem_model.sv ----
// Purpose: byte memory behind the vector fetch port
// Assumes: combinational read, data valid while the read strobe is high
// Notes: each byte follows a fixed formula of its address
`default_nettype none
module cag_mem_model (
  // fetch port
  input wire logic clk_i,
  input wire logic rd_i,
  input wire logic [15:0] addr_i,
  output logic [7:0] data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] last;
  // even and odd bytes answered alike
  always_comb begin
    if (rd_i) begin
      data_o = addr_i[7:0] * 8'h1d + 8'h3c;
    end else begin
      data_o = ~last; // released port never repeats the old byte
    end
  end
  // remember what was last put out
  always_ff @(posedge clk_i) begin
    last <= data_o;
  end
endmodule
`default_nettype wire

// ---- tb/cpu_address_generation_tb.sv ----
// Purpose: self-checking bench for the address generator
// Assumes: partner memory answers in the same cycle
// Notes: random operands from a fixed seed plus corner values
`default_nettype none
module cpu_address_generation_tb;
  import cag_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, start, psel, wide, spld, mrd, ev, rw, aerr, busy, bad;
  cag_op_t op, o;
  logic [15:0] i16, acc, de, hl, spv, fp, stk, ea, maddr, exp;
  logic [7:0] i8, mdat;
  logic [4:0] tix;
  logic [2:0] rc, rsel;
  logic [7:0] crn [4] = '{8'h1f, 8'h20, 8'hff, 8'h00};
  int err_count = 0;
  int tests_run = 0;
  int cyc = 0;
  int seed;
  cag_core u_cag_core (.clk_i(clk), .rst_i(rst), .start_i(start), .op_i(op),
    .imm16_i(i16), .imm8_i(i8), .tbl_idx_i(tix), .reg_code_i(rc),
    .pair_sel_i(psel), .wide_i(wide), .accum_pair_i(acc),
    .second_pair_i(de), .base_pair_i(hl), .sp_load_i(spld),
    .sp_value_i(spv), .mem_data_i(mdat), .mem_rd_o(mrd),
    .mem_addr_o(maddr), .fetch_pointer_o(fp), .stack_top_o(stk),
    .eff_addr_o(ea), .eff_valid_o(ev), .reg_sel_o(rsel),
    .reg_wide_o(rw), .addr_err_o(aerr), .busy_o(busy));
  cag_mem_model u_cag_mem_model (.clk_i(clk), .rd_i(mrd), .addr_i(maddr),
    .data_o(mdat));
  // clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      tally_and_finish();
    end
  end
  function automatic logic [7:0] byte_at(input logic [15:0] a);
    return a[7:0] * 8'h1d + 8'h3c;
  endfunction
  task automatic chk16(input string n, input logic [15:0] x, y);
    tests_run++;
    if (x !== y) begin
      err_count++;
      $display("BAD %s expected %h seen %h", n, x, y);
    end
  endtask
  task automatic chk1(input string n, input logic x, y);
    tests_run++;
    if (x !== y) begin
      err_count++;
      $display("BAD %s expected %b seen %b", n, x, y);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // one strobed request, result settled on return
  task automatic req(input cag_op_t c);
    op <= c;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    #1;
  endtask
  task automatic wait_idle();
    for (int k = 0; k < 20 && busy !== 1'b0; k++) begin
      @(posedge clk);
      #1;
    end
  endtask
  // main sequence
  initial begin
    {start, psel, wide, spld} = '0;
    op = CAG_OP_NONE;
    {i16, acc, de, hl, spv} = '0;
    {i8, tix, rc} = '0;
    seed = $urandom(32'h137bef3f);
    rst = 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    wait_idle();
    exp = {byte_at(16'h0001), byte_at(16'h0000)};
    chk16("fetch_pointer", exp, fp);
    chk1("busy", 1'b0, busy);
    chk1("mem_rd", 1'b0, mrd);
    $display("test reset done");
    for (int n = 0; n < 40; n++) begin
      @(posedge clk);
      i16 <= (n == 2) ? 16'hffff : 16'($urandom());
      acc <= 16'($urandom());
      i8 <= (n < 2) ? 8'h80 - 8'(n) : 8'($urandom());
      tix <= (n == 4) ? 5'h1f : 5'($urandom());
      o = (n < 2) ? CAG_OP_REL : cag_op_t'(1 + $urandom_range(0, 4));
      o = (n == 2) ? CAG_OP_IMM : (n == 3) ? CAG_OP_SEQ : o;
      o = (n == 4) ? CAG_OP_TBL : o;
      req(o);
      case (o)
        CAG_OP_SEQ: exp = exp + 16'h0001;
        CAG_OP_REL: exp = exp + {{8{i8[7]}}, i8};
        CAG_OP_IMM: exp = i16;
        CAG_OP_REG: exp = acc;
        default: begin
          chk1("mem_rd", 1'b1, mrd);
          chk16("mem_addr", 16'h0040 + {10'h000, tix, 1'b0}, maddr);
          chk1("busy", 1'b1, busy);
          wait_idle();
          chk1("busy", 1'b0, busy);
          exp = {byte_at(16'h0041 + {tix, 1'b0}),
            byte_at(16'h0040 + {tix, 1'b0})};
        end
      endcase
      chk16("fetch_pointer", exp, fp);
    end
    $display("test branch done");
    for (int n = 0; n < 60; n++) begin
      @(posedge clk);
      i16 <= 16'($urandom());
      hl <= 16'hff00 | 16'($urandom());
      de <= 16'($urandom());
      i8 <= (n < 4) ? crn[n] : 8'($urandom());
      psel <= 1'($urandom());
      wide <= 1'($urandom());
      rc <= 3'($urandom());
      o = (n < 4) ? CAG_OP_SHORT : cag_op_t'(6 + $urandom_range(0, 4));
      o = (n % 7 == 6) ? CAG_OP_GPR : o;
      req(o);
      bad = 1'b0;
      case (o)
        CAG_OP_DIR: exp = i16;
        CAG_OP_SHORT: begin
          exp = {7'h7f, i8 < 8'h20, i8};
          bad = wide & i8[0];
        end
        CAG_OP_SFR: exp = {8'hff, i8};
        CAG_OP_IND: exp = psel ? hl : de;
        default: exp = hl + {8'h00, i8};
      endcase
      if (o == CAG_OP_GPR) begin
        chk1("reg_wide", wide, rw);
        if (!wide) begin
          chk16("reg_sel", {13'h0, rc}, {13'h0, rsel});
        end else begin
          chk16("reg_sel", {13'h0, rc[2:1], 1'b0}, {13'h0, rsel});
        end
      end else begin
        chk1("addr_err", bad, aerr);
        chk1("eff_valid", !bad, ev);
        if (!bad) begin
          chk16("eff_addr", exp, ea);
        end
      end
    end
    $display("test operand done");
    for (int n = 0; n < 30; n++) begin
      @(posedge clk);
      spv <= (n == 0) ? 16'h1000 : 16'hfd02 + 16'($urandom_range(0, 500));
      spld <= 1'b1;
      @(posedge clk);
      spld <= 1'b0;
      o = n[0] ? CAG_OP_POP : CAG_OP_PUSH;
      req(o);
      exp = (o == CAG_OP_PUSH) ? spv - 16'h0001 : spv;
      chk1("addr_err", n == 0, aerr);
      chk1("eff_valid", n != 0, ev);
      if (n != 0) begin
        chk16("eff_addr", exp, ea);
        chk16("stack_top", n[0] ? spv + 16'h0001 : exp, stk);
      end
    end
    $display("test stack done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
